// *** sas_cfg.svh ***
// Notes on behaviour
// - Convert selected channels in ascending channel order.
// - Source select picks pins or register.
// - Selection latched at convert rise until done.
// - Data bits 0-3 are selection inputs on write.
// - Register captures bits 0-3 at write rise.
// - Convert rise starts sequence, holds all channels.
// - Internal clock: result every 1.65 us, end strobe.
// - Busy stays high until whole sequence converted.
// - Data bus driven only while select and read low; code enables it one clock after they fall and holds it one clock after release.
// - Result stored before end strobe falls.
// - First conversion end resets pointer, raises flag.
// - In sequence, pointer waits for next result.
// - After sequence, each read rise advances pointer.
// - Reading last result wraps pointer to first.
// - First-result flag level undefined after power-up.
// - Clock source input picks internal or external.
// - Each channel takes fourteen conversion clocks.
// - Pointer reset and flag on twelfth clock.
// - Result transfer on thirteenth clock; flag stays set until pointer moves.
// - End strobe low at thirteenth, high fourteenth.
// - Standby low pauses; output registers stay readable.
// - N-th result goes into output register n.
// - Read of last result during sequence wraps pointer.
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

`define SAS_CHANNELS       4
`define SAS_CODE_W         12
`define SAS_SEL_W          4
`define SAS_FIFO_DEPTH     8
`define SAS_MASK_RESET     4'h0
`define SAS_CODE_RESET     12'h000
`define SAS_FLAG_RESET     1'b0
`define SAS_REF_MHZ        25
`define SAS_INT_CONV_NS    1650
`define SAS_CLKS_PER_CONV  14
`define SAS_PTR_RESET_TICK 4'hC
`define SAS_XFER_TICK      4'hD
`define SAS_EOC_RISE_TICK  4'hE
`define SAS_INT_TICK_CYC \
    ((`SAS_INT_CONV_NS * `SAS_REF_MHZ + 500 * `SAS_CLKS_PER_CONV) \
     / (1000 * `SAS_CLKS_PER_CONV))

`endif

// *** sas_pkg.sv ***
`default_nettype none
`include "sas_cfg.svh"

package sas_pkg;

    typedef enum logic [2:0] {
        SAS_IDLE  = 3'b001,
        SAS_CONV  = 3'b010,
        SAS_DRAIN = 3'b100
    } sas_state_t;

    typedef struct packed {
        logic [1:0]               slot;
        logic [`SAS_CODE_W-1:0]   code;
    } sas_result_t;

    typedef logic [`SAS_SEL_W-1:0] sas_mask_t;

endpackage : sas_pkg

`default_nettype wire

// *** sas_sequencer.sv ***
`default_nettype none
`include "sas_cfg.svh"

module sas_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = `SAS_FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic             doWrite;
    logic             doRead;

    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0
                                                            : wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0
                                                            : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule : sas_fifo

module sas_sequencer
    import sas_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   sampleStartN,
    input  wire logic [`SAS_SEL_W-1:0]  hwPickCh,
    input  wire logic                   selectFromReg,
    input  wire logic                   clockSourceSel,
    input  wire logic                   extConvClk,
    input  wire logic                   lowPowerN,
    input  wire logic                   csN,
    input  wire logic                   rdN,
    input  wire logic                   wrN,
    input  wire logic [`SAS_CODE_W-1:0] dataBitIn,
    input  wire logic [`SAS_CODE_W-1:0] adcCode,
    output logic      [`SAS_CODE_W-1:0] dataBitOut,
    output logic      [`SAS_CODE_W-1:0] dataBitOe,
    output logic                        busy,
    output logic                        eocN,
    output logic                        firstResultFlag,
    output logic                        holdAll,
    output logic      [1:0]             convChan
);
    localparam logic [1:0] TICK_DIV_MAX = 2'(`SAS_INT_TICK_CYC - 1);

    // Index of the lowest set bit; the mask is known non-zero where used.
    function automatic logic [1:0] lowestSet(input sas_mask_t m);
        lowestSet = 2'd0;
        for (int i = `SAS_CHANNELS - 1; i >= 0; i--) begin
            if (m[i]) begin
                lowestSet = 2'(i);
            end
        end
    endfunction : lowestSet

    function automatic logic [2:0] popCount(input sas_mask_t m);
        popCount = 3'd0;
        for (int i = 0; i < `SAS_CHANNELS; i++) begin
            popCount = popCount + {2'b00, m[i]};
        end
    endfunction : popCount

    sas_state_t             state_reg;
    sas_mask_t              channelEnableMask_reg;
    sas_mask_t              wrShadow_reg;
    sas_mask_t              pendMask_reg;
    logic [3:0]             tickCnt_reg;
    logic [1:0]             tickDiv_reg;
    logic                   extClkPrev_reg;
    logic                   startPrev_reg;
    logic                   wrPrev_reg;
    logic                   firstConv_reg;
    logic [1:0]             seqIdx_reg;
    logic [2:0]             numSel_reg;
    logic [2:0]             written_reg;
    logic [1:0]             ptr_reg;
    logic                   pend_reg;
    logic [`SAS_CODE_W-1:0] outRegs [`SAS_CHANNELS];

    sas_mask_t   srcMask;
    sas_mask_t   maskAfter;
    logic        startRise;
    logic        wrRise;
    logic        readDone;
    logic        intTick;
    logic        extTick;
    logic        convTick;
    logic [3:0]  tickNum;
    logic        atXfer;
    logic        pushValid;
    logic        fifoInReady;
    logic        tickAdvance;
    logic        drainValid;
    logic        drainReady;
    logic        drainFire;
    sas_result_t pushWord;
    sas_result_t drainWord;

    assign srcMask   = selectFromReg ? channelEnableMask_reg
                                     : hwPickCh;
    assign startRise = !startPrev_reg && sampleStartN;
    assign wrRise    = !wrPrev_reg && wrN;
    assign readDone  = dataBitOe[0] && rdN;
    assign intTick   = (tickDiv_reg == TICK_DIV_MAX);
    assign extTick   = extClkPrev_reg && !extConvClk;
    // Standby freezes the conversion clock; the read side keeps working.
    assign convTick  = lowPowerN && (clockSourceSel ? extTick
                                                    : intTick);
    assign tickNum   = tickCnt_reg + 4'h1;
    assign atXfer    = (tickNum == `SAS_XFER_TICK);
    assign pushValid = (state_reg == SAS_CONV) && convTick && atXfer;
    // A full buffer swallows the transfer tick, so conversion stalls.
    assign tickAdvance = convTick && !(atXfer && !fifoInReady);
    assign maskAfter   = pendMask_reg & ~(sas_mask_t'(1) << convChan);
    // The buffer never overwrites the output word while a read is open.
    // The strobes are watched too, so the word cannot move in the cycle
    // before the enable rises.
    assign drainReady  = !dataBitOe[0] && (csN || rdN);
    assign drainFire   = drainValid && drainReady;
    assign pushWord.slot = seqIdx_reg;
    assign pushWord.code = adcCode;

    sas_fifo #(
        .WIDTH ($bits(sas_result_t)),
        .DEPTH (`SAS_FIFO_DEPTH)
    ) resultFifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushWord),
        .outValid (drainValid),
        .outReady (drainReady),
        .outData  (drainWord)
    );

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            startPrev_reg  <= 1'b1;
            wrPrev_reg     <= 1'b1;
            extClkPrev_reg <= 1'b0;
            tickDiv_reg    <= 2'd0;
        end else begin
            startPrev_reg  <= sampleStartN;
            wrPrev_reg     <= wrN;
            extClkPrev_reg <= extConvClk;
            tickDiv_reg    <= intTick ? 2'd0 : tickDiv_reg + 2'd1;
        end
    end

    // Bits 0-3 are followed while a write is open and committed at its end.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrShadow_reg          <= `SAS_MASK_RESET;
            channelEnableMask_reg <= `SAS_MASK_RESET;
        end else begin
            if (!csN && rdN && !wrN) begin
                wrShadow_reg <= dataBitIn[`SAS_SEL_W-1:0];
            end
            if (wrRise) begin
                channelEnableMask_reg <= wrShadow_reg;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg     <= SAS_IDLE;
            pendMask_reg  <= `SAS_MASK_RESET;
            tickCnt_reg   <= 4'h0;
            convChan      <= 2'd0;
            seqIdx_reg    <= 2'd0;
            numSel_reg    <= 3'd0;
            firstConv_reg <= 1'b0;
            busy          <= 1'b0;
            holdAll       <= 1'b0;
        end else begin
            case (state_reg)
                SAS_IDLE: begin
                    // Starts are only seen here, so busy masks them.
                    if (startRise && lowPowerN && srcMask != '0) begin
                        pendMask_reg  <= srcMask;
                        numSel_reg    <= popCount(srcMask);
                        convChan      <= lowestSet(srcMask);
                        tickCnt_reg   <= 4'h0;
                        seqIdx_reg    <= 2'd0;
                        firstConv_reg <= 1'b1;
                        busy          <= 1'b1;
                        holdAll       <= 1'b1;
                        state_reg     <= SAS_CONV;
                    end
                end
                SAS_CONV: begin
                    if (tickAdvance) begin
                        tickCnt_reg <= tickNum;
                        if (atXfer) begin
                            seqIdx_reg <= seqIdx_reg + 2'd1;
                        end
                        if (tickNum == `SAS_EOC_RISE_TICK) begin
                            tickCnt_reg   <= 4'h0;
                            firstConv_reg <= 1'b0;
                            pendMask_reg  <= maskAfter;
                            if (maskAfter == '0) begin
                                holdAll   <= 1'b0;
                                state_reg <= SAS_DRAIN;
                            end else begin
                                convChan <= lowestSet(maskAfter);
                            end
                        end
                    end
                end
                SAS_DRAIN: begin
                    if (written_reg == numSel_reg) begin
                        busy      <= 1'b0;
                        state_reg <= SAS_IDLE;
                    end
                end
                default: begin
                    state_reg <= SAS_IDLE;
                    busy      <= 1'b0;
                    holdAll   <= 1'b0;
                end
            endcase
        end
    end

    // End strobe falls once the word sits in its output register.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            eocN <= 1'b1;
        end else if (drainFire) begin
            eocN <= 1'b0;
        end else if (state_reg != SAS_CONV
                     || (convTick && tickNum == `SAS_EOC_RISE_TICK)) begin
            eocN <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (drainFire) begin
            outRegs[drainWord.slot] <= drainWord.code;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            written_reg     <= 3'd0;
            ptr_reg         <= 2'd0;
            pend_reg        <= 1'b0;
            firstResultFlag <= `SAS_FLAG_RESET;
        end else begin
            if (state_reg == SAS_IDLE && startRise && lowPowerN
                && srcMask != '0) begin
                written_reg <= 3'd0;
                pend_reg    <= 1'b0;
            end else if (drainFire) begin
                written_reg <= {1'b0, drainWord.slot} + 3'd1;
            end
            if (state_reg == SAS_CONV && firstConv_reg && convTick
                && tickNum == `SAS_PTR_RESET_TICK) begin
                ptr_reg         <= 2'd0;
                pend_reg        <= 1'b0;
                firstResultFlag <= 1'b1;
            end else if (readDone) begin
                if ({1'b0, ptr_reg} + 3'd1 == numSel_reg
                    && written_reg == numSel_reg) begin
                    ptr_reg         <= 2'd0;
                    firstResultFlag <= 1'b1;
                end else if (written_reg <= {1'b0, ptr_reg} + 3'd1) begin
                    pend_reg <= 1'b1;
                end else begin
                    ptr_reg         <= ptr_reg + 2'd1;
                    firstResultFlag <= 1'b0;
                end
            end else if (drainFire && pend_reg
                         && drainWord.slot == ptr_reg + 2'd1) begin
                ptr_reg         <= drainWord.slot;
                pend_reg        <= 1'b0;
                firstResultFlag <= 1'b0;
            end
        end
    end

    // Output enable lags the strobes by one clock so it comes from a flop.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dataBitOe  <= '0;
            dataBitOut <= `SAS_CODE_RESET;
        end else begin
            dataBitOe  <= {`SAS_CODE_W{!csN && !rdN}};
            dataBitOut <= outRegs[ptr_reg];
        end
    end
endmodule : sas_sequencer

`default_nettype wire

// *** sas_seq_chk.sv ***
`default_nettype none
`include "sas_cfg.svh"
module sas_seq_chk (
    input wire logic                   ref_clk,
    input wire logic                   reset,
    input wire logic                   sampleStartN,
    input wire logic [`SAS_SEL_W-1:0]  hwPickCh,
    input wire logic                   selectFromReg,
    input wire logic                   clockSourceSel,
    input wire logic                   lowPowerN,
    input wire logic                   csN,
    input wire logic                   rdN,
    input wire logic [`SAS_CODE_W-1:0] dataBitOut,
    input wire logic [`SAS_CODE_W-1:0] dataBitOe,
    input wire logic                   busy,
    input wire logic                   eocN,
    input wire logic                   firstResultFlag,
    input wire logic                   holdAll
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Gap is only trusted inside a sequence, so the first result is skipped.
    logic [7:0] gap_reg;
    logic       gapOk_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gap_reg   <= 8'h00;
            gapOk_reg <= 1'b0;
        end else begin
            gap_reg   <= $fell(eocN) ? 8'h01 : gap_reg + 8'h01;
            gapOk_reg <= !$rose(busy) && ($fell(eocN) || gapOk_reg);
        end
    end
    property p_oe_gate;
        dataBitOe == {`SAS_CODE_W{!$past(csN) && !$past(rdN)}};
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("bus enable not gated by select and read");
    property p_start;
        $rose(sampleStartN) && !busy && lowPowerN && !selectFromReg
            && hwPickCh != 4'h0 |=> busy && holdAll;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    property p_standby;
        !lowPowerN && !busy |=> !busy;
    endproperty
    a_standby: assert property (p_standby)
        else $error("sequence started in standby");
    property p_eoc_busy;
        $fell(eocN) |-> busy;
    endproperty
    a_eoc_busy: assert property (p_eoc_busy)
        else $error("end strobe outside sequence");
    property p_eoc_width;
        $fell(eocN) && !clockSourceSel |-> ##[1:4] eocN;
    endproperty
    a_eoc_width: assert property (p_eoc_width)
        else $error("end strobe too long");
    property p_gap;
        $fell(eocN) && gapOk_reg && !clockSourceSel
            |-> gap_reg >= 8'h29 && gap_reg <= 8'h2B;
    endproperty
    a_gap: assert property (p_gap)
        else $error("result interval wrong");
    property p_first_eoc;
        $rose(busy) && !clockSourceSel |-> ##[36:48] $fell(eocN);
    endproperty
    a_first_eoc: assert property (p_first_eoc)
        else $error("first result late");
    property p_flag;
        $rose(firstResultFlag) && busy && !clockSourceSel
            |-> ##[2:8] $fell(eocN);
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag not ahead of end strobe");
    property p_hold;
        holdAll |-> busy;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold outside sequence");
    property p_read_stable;
        $past(dataBitOe[0]) && dataBitOe[0] |-> $stable(dataBitOut);
    endproperty
    a_read_stable: assert property (p_read_stable)
        else $error("data changed during read");
endmodule : sas_seq_chk
bind sas_sequencer sas_seq_chk u_sas_seq_chk (
    .ref_clk, .reset, .sampleStartN, .hwPickCh, .selectFromReg,
    .clockSourceSel, .lowPowerN, .csN, .rdN, .dataBitOut, .dataBitOe,
    .busy, .eocN, .firstResultFlag, .holdAll
);
`default_nettype wire

// *** sas_host_model.sv ***
`default_nettype none
`include "sas_cfg.svh"
module sas_host_model (
    input  wire logic                   ref_clk,
    input  wire logic [`SAS_CODE_W-1:0] dataBitOut,
    input  wire logic [`SAS_CODE_W-1:0] dataBitOe,
    output logic                        csN,
    output logic                        rdN,
    output logic                        wrN,
    output logic                        sampleStartN,
    output logic                        lowPowerN,
    output logic      [`SAS_CODE_W-1:0] dataBitIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN          = 1'b1;
        rdN          = 1'b1;
        wrN          = 1'b1;
        sampleStartN = 1'b1;
        lowPowerN    = 1'b1;
        dataBitIn    = 12'h5A5;
    end
    task automatic wr_mask(input logic [3:0] m);
        @(posedge ref_clk);
        csN       <= 1'b0;
        wrN       <= 1'b0;
        dataBitIn <= {8'h00, m};
        repeat (2) @(posedge ref_clk);
        wrN <= 1'b1;
        csN <= 1'b1;
        @(posedge ref_clk);
        // A released bus must not keep showing the old word.
        dataBitIn <= ~dataBitIn;
    endtask : wr_mask
    task automatic start();
        @(posedge ref_clk);
        sampleStartN <= 1'b0;
        @(posedge ref_clk);
        sampleStartN <= 1'b1;
    endtask : start
    task automatic rd(output logic [`SAS_CODE_W-1:0] v);
        @(posedge ref_clk);
        csN <= 1'b0;
        rdN <= 1'b0;
        for (int n = 0; n < 8 && dataBitOe !== '1; n++) @(negedge ref_clk);
        v = dataBitOut;
        @(posedge ref_clk);
        rdN <= 1'b1;
        csN <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : rd
    task automatic standby(input logic on);
        @(posedge ref_clk);
        lowPowerN <= ~on;
        if (!on) repeat (2000 / 40) @(posedge ref_clk);
    endtask : standby
endmodule : sas_host_model
`default_nettype wire

// *** sas_sequencer_tb.sv ***
`default_nettype none
`include "sas_cfg.svh"
module sas_sequencer_tb
    import sas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic      fromReg;
        sas_mask_t hw;
        sas_mask_t regMask;
    } sas_row_t;
    localparam sas_row_t ROWS [4] = '{'{1'b0, 4'hD, 4'h2},
        '{1'b1, 4'h1, 4'hA}, '{1'b1, 4'h0, 4'hF}, '{1'b0, 4'h8, 4'h0}};
    logic                   ref_clk, reset, selectFromReg, clockSourceSel;
    logic                   extConvClk, busy, eocN, eocSeen, holdAll;
    logic                   sampleStartN, lowPowerN, csN, rdN, wrN;
    logic                   firstResultFlag;
    sas_mask_t              hwPickCh, mask;
    logic [`SAS_CODE_W-1:0] dataBitIn, dataBitOut, dataBitOe, adcCode, v;
    logic [1:0]             convChan;
    logic [`SAS_CODE_W-1:0] want [$];
    sas_row_t               r;
    int                     failures, checksDone, eocFalls, extDiv, cyc, n;
    // Each channel gives its own code, so order mistakes show up.
    assign adcCode = 12'hA50 + {10'h000, convChan};
    sas_sequencer u_sas_sequencer (.ref_clk, .reset, .sampleStartN,
        .hwPickCh, .selectFromReg, .clockSourceSel, .extConvClk,
        .lowPowerN, .csN, .rdN, .wrN, .dataBitIn, .adcCode, .dataBitOut,
        .dataBitOe, .busy, .eocN, .firstResultFlag, .holdAll, .convChan);
    sas_host_model u_sas_host_model (.ref_clk, .dataBitOut, .dataBitOe,
        .csN, .rdN, .wrN, .sampleStartN, .lowPowerN, .dataBitIn);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Six reference clocks per period keeps the external clock below 5 MHz.
    always @(posedge ref_clk) begin
        extDiv <= (extDiv == 2) ? 0 : extDiv + 1;
        if (extDiv == 2) extConvClk <= ~extConvClk;
    end
    always @(negedge ref_clk) begin
        eocSeen <= eocN;
        if (eocSeen === 1'b1 && eocN === 1'b0) eocFalls++;
        if (holdAll === 1'b1) cyc++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (failures == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 400 && busy !== lvl; k++) @(negedge ref_clk);
        check(busy, lvl);
    endtask : wait_busy
    task automatic expect_list(input sas_mask_t m);
        mask = m;
        want.delete();
        for (int c = 0; c < `SAS_CHANNELS; c++) begin
            if (mask[c]) want.push_back(12'hA50 + 12'(c));
        end
        eocFalls = 0;
    endtask : expect_list
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        hwPickCh = 4'h0;
        selectFromReg = 1'b0;
        clockSourceSel = 1'b0;
        extConvClk = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (ROWS[i]) begin
            r = ROWS[i];
            u_sas_host_model.wr_mask(r.regMask);
            hwPickCh <= r.hw;
            selectFromReg <= r.fromReg;
            expect_list(r.fromReg ? r.regMask : r.hw);
            u_sas_host_model.start();
            wait_busy(1'b1);
            @(posedge ref_clk);
            hwPickCh <= ~r.hw;
            u_sas_host_model.start();
            wait_busy(1'b0);
            check(eocFalls, want.size());
            check(firstResultFlag, 1'b1);
            for (int p = 0; p <= want.size(); p++) begin
                u_sas_host_model.rd(v);
                check(v, want[p % want.size()]);
                if (p == 0) check(firstResultFlag, want.size() == 1);
            end
        end
        // Reads right after each end strobe, the first one repeated.
        hwPickCh <= 4'hF;
        selectFromReg <= 1'b0;
        expect_list(4'hF);
        u_sas_host_model.start();
        for (int k = 0; k < 4; k++) begin
            for (n = 0; n < 200 && eocFalls <= k; n++) @(negedge ref_clk);
            repeat (1 + (k == 0)) begin
                u_sas_host_model.rd(v);
                check(v, want[k]);
            end
        end
        wait_busy(1'b0);
        u_sas_host_model.rd(v);
        check(v, want[0]);
        u_sas_host_model.standby(1'b1);
        u_sas_host_model.start();
        repeat (8) @(posedge ref_clk);
        check(busy, 1'b0);
        u_sas_host_model.rd(v);
        check(v, want[1]);
        u_sas_host_model.standby(1'b0);
        clockSourceSel <= 1'b1;
        hwPickCh <= 4'h4;
        u_sas_host_model.start();
        cyc = 0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (8) @(negedge ref_clk);
        check(cyc >= 78 && cyc <= 90, 1'b1);
        u_sas_host_model.rd(v);
        check(v, 12'hA52);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(negedge ref_clk);
        check({busy, eocN, firstResultFlag, holdAll, dataBitOe},
              16'h4000);
        @(posedge ref_clk);
        reset <= 1'b0;
        selectFromReg <= 1'b1;
        clockSourceSel <= 1'b0;
        u_sas_host_model.start();
        repeat (4) @(posedge ref_clk);
        check(busy, 1'b0);
        conclude();
    end
endmodule : sas_sequencer_tb
`default_nettype wire
